/* ttcm_pkg.sv */
package ttcm_pkg;

  localparam int unsigned CLK_MHZ         = 25;
  // Longest clock-off interval, in nanoseconds
  localparam int unsigned OFF_MAX_NS      = 3000;
  localparam int unsigned OFF_CYC         = (OFF_MAX_NS * CLK_MHZ) / 1000;
  // Hysteresis hold before leaving the hot state, in nanoseconds
  localparam int unsigned HYST_NS         = 1000;
  localparam int unsigned HYST_CYC        = (HYST_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W           = 12;

  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STAT       = 12'h004;
  localparam logic [11:0] ADDR_EVCNT      = 12'h008;

  localparam int unsigned CTRL_AUTO_EN    = 0;
  localparam int unsigned CTRL_OD_EN      = 1;
  localparam int unsigned CTRL_OD_DUTY_LO = 2;
  localparam int unsigned CTRL_OD_DUTY_HI = 4;

  localparam int unsigned STAT_SENSOR_HOT = 0;
  localparam int unsigned STAT_PIN_LOW    = 1;
  localparam int unsigned STAT_HOT        = 2;
  localparam int unsigned STAT_THROTTLE   = 3;
  localparam int unsigned STAT_CLK_OFF    = 4;
  localparam int unsigned STAT_HOT_LOG    = 5;

  localparam logic [2:0]  AUTO_DUTY_DFLT  = 3'h4;
  localparam logic [2:0]  DUTY_ZERO       = 3'h0;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  typedef struct packed {
    logic       auto_en;
    logic       od_en;
    logic [2:0] od_duty;
  } ttcm_ctrl_t;

  typedef struct packed {
    logic       throttle;
    logic [2:0] duty;
  } ttcm_mod_req_t;

endpackage : ttcm_pkg

/* ttcm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ttcm_sync
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } ttcm_sync_st_t;

  ttcm_sync_st_t st_r;
  ttcm_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{s1: 1'b1, s2: 1'b1};
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule // ttcm_sync
`default_nettype wire

/* ttcm_mod.sv */
`timescale 1ns/1ps
`default_nettype none
module ttcm_mod
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire ttcm_pkg::ttcm_mod_req_t req,
  output logic                        clk_en,
  output logic                        off_start
);

  typedef enum logic [1:0] {
    M_ON  = 2'b01,
    M_OFF = 2'b10
  } ttcm_mstate_t;

  typedef struct packed {
    ttcm_mstate_t                       state;
    logic [ttcm_pkg::CNT_W-1:0]         cnt;
    logic                               pulse;
  } ttcm_mod_st_t;

  ttcm_mod_st_t st_r;
  ttcm_mod_st_t st_nxt;
  logic [ttcm_pkg::CNT_W-1:0] on_len;

  // On time = OFF * k / (8 - k); off time stays fixed
  always_comb
  begin
    on_len = ttcm_pkg::CNT_W'((ttcm_pkg::OFF_CYC * 32'(req.duty))
             / (32'd8 - 32'(req.duty)));
  end

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.pulse = 1'b0;
    case (st_r.state)
      M_ON:
      begin
        if (!req.throttle || req.duty == ttcm_pkg::DUTY_ZERO)
          st_nxt.cnt = '0;
        else if (st_r.cnt + 1'b1 >= on_len)
        begin
          st_nxt.state = M_OFF;
          st_nxt.cnt   = '0;
          st_nxt.pulse = 1'b1;
        end
        else
          st_nxt.cnt = st_r.cnt + 1'b1;
      end
      M_OFF:
      begin
        if (!req.throttle || st_r.cnt + 1'b1 >= ttcm_pkg::CNT_W'(ttcm_pkg::OFF_CYC))
        begin
          st_nxt.state = M_ON;
          st_nxt.cnt   = '0;
        end
        else
          st_nxt.cnt = st_r.cnt + 1'b1;
      end
      default:
      begin
        st_nxt.state = M_ON;
        st_nxt.cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{state: M_ON, cnt: '0, pulse: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign clk_en    = (st_r.state != M_OFF);
  assign off_start = st_r.pulse;

  AST_OFF_BOUND: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(!clk_en) |-> ##[1:75] clk_en)
    else $error("Clock-off interval exceeds bound");

endmodule // ttcm_mod
`default_nettype wire

/* ttcm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ttcm_top
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        temp_at_trip,
  input  wire logic [2:0]  auto_duty_fuse,
  input  wire logic        over_temp_indicator_n_i,
  output logic             over_temp_indicator_n_o,
  output logic             over_temp_indicator_n_oe,
  output logic             core_clk_en,
  output logic             thermal_hot,
  output logic             perf_throttle_evt
);

  typedef struct packed {
    ttcm_pkg::ttcm_ctrl_t ctrl;
    logic                 wr_pend;
    logic                 rd_pend;
    logic [11:0]          addr;
    logic                 hot;
    logic [ttcm_pkg::CNT_W-1:0] hyst;
    logic                 hot_log;
    logic [31:0]          evcnt;
    logic [2:0]           auto_duty;
    logic                 fuse_done;
    logic [31:0]          rdata;
  } ttcm_st_t;

  ttcm_st_t st_r;
  ttcm_st_t st_nxt;
  logic sensor_s;
  logic temp_n_s;
  logic pin_low_s;
  logic pin_s;
  logic clk_en;
  logic off_start;
  ttcm_pkg::ttcm_mod_req_t req;

  ttcm_sync u_sync_temp
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (~temp_at_trip),
    .q       (temp_n_s)
  );

  // Synchroniser idles high, so the cool level is its reset level
  assign sensor_s = ~temp_n_s;

  ttcm_sync u_sync_pin
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (over_temp_indicator_n_i),
    .q       (pin_s)
  );

  assign pin_low_s = ~pin_s;

  // Throttle request with automatic priority
  always_comb
  begin
    req.throttle = 1'b0;
    req.duty     = st_r.ctrl.od_duty;
    if ((st_r.hot || pin_low_s) && st_r.ctrl.auto_en)
    begin
      req.throttle = 1'b1;
      req.duty     = st_r.auto_duty;
    end
    else if (st_r.ctrl.od_en && st_r.ctrl.od_duty != ttcm_pkg::DUTY_ZERO)
      req.throttle = 1'b1;
  end

  ttcm_mod u_mod
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .req       (req),
    .clk_en    (clk_en),
    .off_start (off_start)
  );

  function automatic logic [31:0] rd_mux(input ttcm_st_t s, input logic [11:0] a,
                                         input logic sh, input logic pl, input logic ce);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      ttcm_pkg::ADDR_CTRL:
      begin
        v[ttcm_pkg::CTRL_AUTO_EN] = s.ctrl.auto_en;
        v[ttcm_pkg::CTRL_OD_EN]   = s.ctrl.od_en;
        v[ttcm_pkg::CTRL_OD_DUTY_HI:ttcm_pkg::CTRL_OD_DUTY_LO] = s.ctrl.od_duty;
      end
      ttcm_pkg::ADDR_STAT:
      begin
        v[ttcm_pkg::STAT_SENSOR_HOT] = sh;
        v[ttcm_pkg::STAT_PIN_LOW]    = pl;
        v[ttcm_pkg::STAT_HOT]        = s.hot;
        v[ttcm_pkg::STAT_THROTTLE]   = ((s.hot | pl) & s.ctrl.auto_en)
                                       | (s.ctrl.od_en
                                          & (s.ctrl.od_duty != ttcm_pkg::DUTY_ZERO));
        v[ttcm_pkg::STAT_CLK_OFF]    = ~ce;
        v[ttcm_pkg::STAT_HOT_LOG]    = s.hot_log;
      end
      ttcm_pkg::ADDR_EVCNT:
        v = s.evcnt;
      default:
        v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    // Latch fused duty once after reset release
    if (!st_r.fuse_done)
    begin
      st_nxt.auto_duty = (auto_duty_fuse == ttcm_pkg::DUTY_ZERO)
                         ? ttcm_pkg::AUTO_DUTY_DFLT : auto_duty_fuse;
      st_nxt.fuse_done = 1'b1;
    end
    // Hot state with time hysteresis on release
    if (sensor_s)
    begin
      st_nxt.hot  = 1'b1;
      st_nxt.hyst = ttcm_pkg::CNT_W'(ttcm_pkg::HYST_CYC);
    end
    else if (st_r.hyst != '0)
      st_nxt.hyst = st_r.hyst - 1'b1;
    else
      st_nxt.hot = 1'b0;
    if (off_start)
      st_nxt.evcnt = st_r.evcnt + 32'h0000_0001;
    // AHB-Lite data phase
    st_nxt.wr_pend = 1'b0;
    st_nxt.rd_pend = 1'b0;
    if (st_r.wr_pend && st_r.addr == ttcm_pkg::ADDR_CTRL)
    begin
      st_nxt.ctrl.auto_en = hwdata[ttcm_pkg::CTRL_AUTO_EN];
      st_nxt.ctrl.od_en   = hwdata[ttcm_pkg::CTRL_OD_EN];
      st_nxt.ctrl.od_duty =
        hwdata[ttcm_pkg::CTRL_OD_DUTY_HI:ttcm_pkg::CTRL_OD_DUTY_LO];
    end
    if (st_r.wr_pend && st_r.addr == ttcm_pkg::ADDR_STAT
        && hwdata[ttcm_pkg::STAT_HOT_LOG])
      st_nxt.hot_log = 1'b0;
    if (st_r.hot)
      st_nxt.hot_log = 1'b1;
    if (hsel && hready && htrans == ttcm_pkg::HTRANS_NONSEQ)
    begin
      st_nxt.wr_pend = hwrite;
      st_nxt.rd_pend = ~hwrite;
      st_nxt.addr    = haddr[11:0];
      st_nxt.rdata   = rd_mux(st_r, haddr[11:0], sensor_s, pin_low_s, clk_en);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{ctrl: '{auto_en: 1'b0, od_en: 1'b0, od_duty: 3'h0},
                wr_pend: 1'b0, rd_pend: 1'b0, addr: 12'h000, hot: 1'b0,
                hyst: '0, hot_log: 1'b0, evcnt: 32'h0000_0000,
                auto_duty: ttcm_pkg::AUTO_DUTY_DFLT, fuse_done: 1'b0,
                rdata: 32'h0000_0000};
    else
      st_r <= st_nxt;
  end

  assign hrdata    = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Open-drain: drive low only, never high
  assign over_temp_indicator_n_o  = 1'b0;
  assign over_temp_indicator_n_oe = st_r.hot;
  assign core_clk_en       = clk_en;
  assign thermal_hot       = st_r.hot | pin_low_s;
  assign perf_throttle_evt = off_start;

  sequence s_trip;
    sensor_s;
  endsequence

  AST_HOT_ASSERT: assert property (@(posedge hclk) disable iff (!hresetn)
    s_trip |=> over_temp_indicator_n_oe)
    else $error("Indicator not driven after trip");
  AST_HOT_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    !sensor_s [*8] |-> ##[1:30] !over_temp_indicator_n_oe)
    else $error("Indicator not released after cooling");
  AST_NO_GATE_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_r.ctrl.auto_en && !st_r.ctrl.od_en) |=> ##1 core_clk_en)
    else $error("Clock gated with throttling disabled");
  AST_IND_INDEP: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_r.hot) |-> $past(sensor_s))
    else $error("Hot state set without a trip");
  AST_PIN_THROTTLE: assert property (@(posedge hclk) disable iff (!hresetn)
    (pin_low_s && st_r.ctrl.auto_en) |-> req.throttle)
    else $error("External request did not throttle");
  AST_AUTO_PRIO: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.hot && st_r.ctrl.auto_en) |-> req.duty == st_r.auto_duty)
    else $error("Automatic duty not taking precedence");
  AST_OD_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.ctrl.od_en && st_r.ctrl.od_duty != 3'h0) |-> req.throttle)
    else $error("On-demand request not throttling");
  AST_FUSE_FIXED: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.fuse_done |=> $stable(st_r.auto_duty))
    else $error("Fused duty changed at runtime");
  AST_EVT_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
    perf_throttle_evt |=> st_r.evcnt == $past(st_r.evcnt) + 32'h0000_0001)
    else $error("Throttle event not counted");

endmodule // ttcm_top
`default_nettype wire

/* ttcm_board.sv */
`timescale 1ns/1ps
`default_nettype none
module ttcm_board
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       pull_req,
  input  wire logic [3:0] lag,
  input  wire logic       pin,
  output logic            pull_oe,
  output logic [7:0]      edge_cnt
);
  logic [3:0] wait_r;
  logic       pin_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_r   <= 4'h0;
      pull_oe  <= 1'b0;
      pin_r    <= 1'b1;
      edge_cnt <= 8'h00;
    end
    else
    begin
      // Slow or prompt pull on the shared line
      if (pull_req == pull_oe)
        wait_r <= 4'h0;
      else if (wait_r >= lag)
        pull_oe <= pull_req;
      else
        wait_r <= wait_r + 4'h1;
      // Edge watcher as an interrupt source would see it
      pin_r <= pin;
      if (pin_r != pin)
        edge_cnt <= edge_cnt + 8'h01;
    end
  end
endmodule // ttcm_board
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        hclk, hresetn, hsel, hwrite, hready, temp_at_trip, pull_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, fuse;
  logic [3:0]  lag;
  logic        hreadyout, hresp, oe, pin_o, clk_en, hot, evt, board_oe;
  logic [7:0]  edges;
  logic        ce_q = 1'b1;
  int          n_off = 0;
  int          n_evt = 0;
  int          n_mismatch, num_checks, n, off, on;
  // Pull-up on the open-drain line
  wire logic   pin = ~(oe | board_oe);

  ttcm_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .temp_at_trip(temp_at_trip),
    .auto_duty_fuse(fuse), .over_temp_indicator_n_i(pin), .over_temp_indicator_n_o(pin_o),
    .over_temp_indicator_n_oe(oe), .core_clk_en(clk_en), .thermal_hot(hot),
    .perf_throttle_evt(evt));
  ttcm_board board (.hclk(hclk), .hresetn(hresetn), .pull_req(pull_req), .lag(lag),
    .pin(pin), .pull_oe(board_oe), .edge_cnt(edges));

  // Off intervals seen on the clock enable, and event pulses
  always @(posedge hclk)
  begin
    ce_q <= clk_en;
    if (hresetn && ce_q && !clk_en)
      n_off++;
    if (hresetn && evt === 1'b1)
      n_evt++;
  end

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task tmo;
    n_mismatch++;
    $display("ERROR %0t wait ran out", $time);
    end_sim;
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task chk_len(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("ERROR %0t length %0d expected %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= ttcm_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    k = 0;
    do begin @(posedge hclk); k++; if (k > 50) tmo(); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    do begin @(posedge hclk); k++; if (k > 50) tmo(); end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic sg(input bit s);
    return s ? oe : clk_en;
  endfunction

  function automatic int onl(input int k);
    return int'(ttcm_pkg::OFF_CYC) * k / (8 - k);
  endfunction

  task wt(input bit s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (sg(s) !== v)
    begin
      @(posedge hclk);
      cnt++;
      if (cnt > lim)
        tmo();
    end
  endtask

  // One whole off interval and the on interval after it
  task meas(input int k);
    int t;
    wt(0, 1'b1, 3000, t);
    wt(0, 1'b0, 3000, t);
    wt(0, 1'b1, 200, off);
    wt(0, 1'b0, 3000, on);
    chk_len(off, ttcm_pkg::OFF_CYC - 1, ttcm_pkg::OFF_CYC);
    chk_len(on, onl(k) - 1, onl(k) + 1);
  endtask

  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; hready = 1'b1; temp_at_trip = 1'b0; pull_req = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(33));
    fuse = 3'(1 + $urandom % 7);
    lag = 4'($urandom % 8);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, ttcm_pkg::ADDR_CTRL, 32'h0);
    chk_word(rd, 32'h0);
    ahb(1'b1, ttcm_pkg::ADDR_CTRL, 32'hFFFF_FFE0);
    ahb(1'b0, ttcm_pkg::ADDR_CTRL, 32'h0);
    chk_word(rd, 32'h0);
    ahb(1'b1, 32'h0000_000C, $urandom);
    ahb(1'b0, 32'h0000_000C, 32'h0);
    chk_word(rd, 32'h0);
    temp_at_trip <= 1'b1;
    wt(1, 1'b1, 20, n);
    chk_len(n, 2, 4);
    n = 0;
    repeat (300) begin @(posedge hclk); if (clk_en !== 1'b1) n++; end
    chk_len(n, 0, 0);
    ahb(1'b0, ttcm_pkg::ADDR_STAT, 32'h0);
    chk_word(rd & 32'h0000_003F, 32'h0000_0027);
    chk_word({31'h0, hot}, 32'h1);
    temp_at_trip <= 1'b0;
    wt(1, 1'b0, 100, n);
    chk_len(n, ttcm_pkg::HYST_CYC, ttcm_pkg::HYST_CYC + 4);
    repeat (4) @(posedge hclk);
    chk_len(int'(edges), 2, 2);
    ahb(1'b1, ttcm_pkg::ADDR_CTRL, 32'h1);
    temp_at_trip <= 1'b1;
    meas(int'(fuse));
    ahb(1'b1, ttcm_pkg::ADDR_CTRL, 32'h7);
    meas(int'(fuse));
    ahb(1'b0, ttcm_pkg::ADDR_STAT, 32'h0);
    chk_word({31'h0, rd[ttcm_pkg::STAT_THROTTLE]}, 32'h1);
    temp_at_trip <= 1'b0;
    wt(1, 1'b0, 100, n);
    for (int k = 1; k < 8; k++)
    begin
      ahb(1'b1, ttcm_pkg::ADDR_CTRL, 32'h2 | (k << 2));
      meas(k);
    end
    ahb(1'b1, ttcm_pkg::ADDR_CTRL, 32'h1);
    pull_req <= 1'b1;
    meas(int'(fuse));
    chk_word({29'h0, pin_o, oe, hot}, 32'h1);
    pull_req <= 1'b0;
    ahb(1'b1, ttcm_pkg::ADDR_CTRL, 32'h0);
    repeat (10) @(posedge hclk);
    ahb(1'b0, ttcm_pkg::ADDR_EVCNT, 32'h0);
    chk_word(rd, 32'(n_off));
    chk_word(32'(n_evt), 32'(n_off));
    chk_word({31'h0, hresp}, 32'h0);
    end_sim;
  end
endmodule // tb
`default_nettype wire
